// file: i2cm_pkg.sv
// Shared constants for the two-wire bus master block
package i2cm_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_TX     = 8'h9A;
  localparam logic [7:0] IDX_RX     = 8'h9B;
  localparam logic [7:0] IDX_CFG    = 8'hAF;
  localparam logic [7:0] IDX_MODE   = 8'hE8;
  localparam logic [7:0] IDX_ADR    = 8'hE9;
  localparam logic [7:0] IDX_STAT   = 8'hEA;
  localparam logic [7:0] IDX_MASK   = 8'hEB;
  // Field positions
  localparam int         CFG_PSEL_BIT  = 0;
  localparam int         MODE_EN_BIT   = 7;
  localparam int         MODE_RATE_LSB = 5;
  localparam int         ST_BUSY       = 7;
  localparam int         ST_NOACK      = 6;
  localparam int         ST_RX         = 5;
  localparam int         ST_TX         = 4;
  localparam int         ST_TXWR       = 0;
  localparam logic [7:0] STAT_FLAGS    = 8'h71;
  // Reset values
  localparam logic [7:0] RST_REG8      = 8'h00;
  // Bus clock period in core cycles is DIV_BASE shifted by the rate code
  localparam int         DIV_BASE      = 16;
  localparam int         QUARTER_BASE  = DIV_BASE / 4;
  localparam logic [6:0] QUARTER_MAX   = 7'h20;
  localparam logic [3:0] ACK_BIT       = 4'h8;
endpackage

// file: i2cm_master.sv
// Two-wire bus master with register slave on APB
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Port select bit routes pins to one peripheral
// - Pins only pulled low or released while port select routes them to the two-wire master
// - Start only on idle bus, address first
// - Data phase only after address acknowledge
// - Bytes continue until stop, then idle
// - Master makes clock at one of four rates
// - Clock period is 16 shifted by rate
// - Enable bit gates launch by address write
// - Address bits 7..1, direction bit 0
// - Direction one reads into receive buffer
// - Direction zero writes from transmit buffer
// - Read ends after count plus one bytes
// - Separate buffer and register addresses
// - Missing acknowledge sets flag, halts transfer
// - Transmit empty and receive data flags
// - Automatic master acknowledge, final no-acknowledge
// - Address rewrite mid-transfer gives repeated start
module i2cm_master
  import i2cm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        spi_sclk_o,
  input  wire logic        spi_sclk_oe,
  input  wire logic        spi_mosi_o,
  input  wire logic        spi_mosi_oe,
  output logic             irq
);

  // ********************************
  // State
  // ********************************
  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_STOP, S_RESTART} i2cm_state_t;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  mode;
    logic [7:0]  adr;
    logic [7:0]  mask;
    logic [7:0]  flags;
    logic [7:0]  txb;
    logic        txfull;
    logic [7:0]  rxb;
    i2cm_state_t st;
    logic [1:0]  ph;
    logic [6:0]  div;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic        is_adr;
    logic        rd;
    logic        nack;
    logic [4:0]  cnt;
    logic        pend;
    logic        scl_dr;
    logic        sda_dr;
  } i2cm_regs_t;

  i2cm_regs_t r_reg;
  i2cm_regs_t r_next;

  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] idx;
  logic       hit;
  logic       tick;
  logic [6:0] quarter;
  logic       psel_i2c;
  logic       last;

  // ********************************
  // APB decode
  // ********************************
  assign idx     = paddr[9:2];
  assign hit     = idx inside {IDX_TX, IDX_RX, IDX_CFG, IDX_MODE, IDX_ADR, IDX_STAT, IDX_MASK};
  assign wr_acc  = psel && penable && pwrite && hit;
  assign rd_acc  = psel && penable && !pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (idx)
        IDX_RX:   prdata[7:0] = r_reg.rxb;
        IDX_CFG:  prdata[7:0] = r_reg.cfg;
        IDX_MODE: prdata[7:0] = r_reg.mode;
        IDX_ADR:  prdata[7:0] = r_reg.adr;
        IDX_STAT: prdata[7:0] = {r_reg.st != S_IDLE, r_reg.flags[6:4],
                                 r_reg.txfull ? 2'b11 : 2'b00, r_reg.flags[1:0]};
        IDX_MASK: prdata[7:0] = r_reg.mask;
        default:  prdata = 32'h0000_0000;
      endcase
    end
  end

  // ********************************
  // Clock divider and pins
  // ********************************
  assign psel_i2c = r_reg.cfg[CFG_PSEL_BIT];
  assign quarter  = 7'(QUARTER_BASE) << r_reg.mode[MODE_RATE_LSB +: 2];
  assign tick     = ce && (r_reg.st != S_IDLE) && (r_reg.div == quarter - 7'h01);
  assign last     = !r_reg.is_adr && (r_reg.cnt == r_reg.mode[4:0]);

  assign scl_o  = psel_i2c ? 1'b0 : spi_sclk_o;
  assign sda_o  = psel_i2c ? 1'b0 : spi_mosi_o;
  assign scl_oe = psel_i2c ? r_reg.scl_dr : spi_sclk_oe;
  assign sda_oe = psel_i2c ? r_reg.sda_dr : spi_mosi_oe;
  assign irq    = |(r_reg.flags & r_reg.mask & STAT_FLAGS);

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    r_next = r_reg;
    if (ce) begin
      if (wr_acc) begin
        case (idx)
          IDX_CFG:  r_next.cfg = pwdata[7:0];
          IDX_MODE: r_next.mode = pwdata[7:0];
          IDX_MASK: r_next.mask = pwdata[7:0];
          IDX_STAT: r_next.flags = r_reg.flags & (pwdata[7:0] | ~STAT_FLAGS);
          IDX_ADR: begin
            r_next.adr = pwdata[7:0];
            if (r_reg.mode[MODE_EN_BIT])
              r_next.pend = 1'b1;
          end
          default: r_next.cfg = r_reg.cfg;
        endcase
      end
      if (r_reg.st == S_IDLE)
        r_next.div = 7'h00;
      else if (tick)
        r_next.div = 7'h00;
      else
        r_next.div = r_reg.div + 7'h01;
      case (r_reg.st)
        S_IDLE: begin
          r_next.ph = 2'b00;
          if (r_reg.pend && r_reg.mode[MODE_EN_BIT] && psel_i2c && scl_i && sda_i) begin
            r_next.st = S_START;
            r_next.div = 7'h00;
          end
        end
        S_START: if (tick) begin
          r_next.ph = r_reg.ph + 2'b01;
          if (r_reg.ph == 2'b00)
            r_next.sda_dr = 1'b1;
          if (r_reg.ph == 2'b01) begin
            r_next.scl_dr = 1'b1;
            r_next.st     = S_BIT;
            r_next.ph     = 2'b00;
            r_next.bitc   = 4'h0;
            r_next.sh     = r_next.adr;
            r_next.is_adr = 1'b1;
            r_next.pend   = 1'b0;
            r_next.cnt    = 5'h00;
          end
        end
        S_BIT: if (tick) begin
          r_next.ph = r_reg.ph + 2'b01;
          case (r_reg.ph)
            2'b00: begin
              r_next.scl_dr = 1'b1;
              if (r_reg.bitc != ACK_BIT)
                r_next.sda_dr = (r_reg.is_adr || !r_reg.rd) && !r_reg.sh[7];
              else
                r_next.sda_dr = !r_reg.is_adr && r_reg.rd && !last;
            end
            2'b01: r_next.scl_dr = 1'b0;
            2'b10: begin
              if (r_reg.bitc != ACK_BIT)
                r_next.sh = {r_reg.sh[6:0], sda_i};
              else
                r_next.nack = sda_i;
            end
            default: begin
              r_next.scl_dr = 1'b1;
              r_next.bitc   = r_reg.bitc + 4'h1;
              if (r_reg.bitc == ACK_BIT) begin
                r_next.bitc   = 4'h0;
                r_next.is_adr = 1'b0;
                if (r_reg.is_adr)
                  r_next.rd = r_reg.sh[0] ^ 1'b0;
                if (!r_reg.is_adr && r_reg.rd) begin
                  r_next.rxb          = r_reg.sh;
                  r_next.flags[ST_RX] = 1'b1;
                  r_next.cnt          = r_reg.cnt + 5'h01;
                end
                if ((r_reg.is_adr || !r_reg.rd) && r_reg.nack) begin
                  r_next.flags[ST_NOACK] = 1'b1;
                  r_next.st              = S_STOP;
                  if (r_reg.txfull)
                    r_next.flags[ST_TX] = 1'b1;
                  r_next.txfull = 1'b0;
                end else if (r_reg.pend) begin
                  r_next.st = S_RESTART;
                end else if (r_reg.is_adr ? r_reg.adr[0] : r_reg.rd) begin
                  if (last)
                    r_next.st = S_STOP;
                end else if (r_reg.txfull) begin
                  r_next.sh           = r_reg.txb;
                  r_next.txfull       = 1'b0;
                  r_next.flags[ST_TX] = 1'b1;
                end else begin
                  r_next.st = S_STOP;
                end
              end
            end
          endcase
        end
        S_RESTART: if (tick) begin
          r_next.ph = r_reg.ph + 2'b01;
          case (r_reg.ph)
            2'b00:   r_next.sda_dr = 1'b0;
            2'b01:   r_next.scl_dr = 1'b0;
            2'b10:   r_next.sda_dr = 1'b1;
            default: begin
              r_next.st = S_START;
              r_next.ph = 2'b01;
            end
          endcase
        end
        S_STOP: if (tick) begin
          r_next.ph = r_reg.ph + 2'b01;
          case (r_reg.ph)
            2'b00:   r_next.sda_dr = 1'b1;
            2'b01:   r_next.scl_dr = 1'b0;
            2'b10:   r_next.sda_dr = 1'b0;
            default: r_next.st = S_IDLE;
          endcase
        end
        default: r_next.st = S_IDLE;
      endcase
      if (wr_acc && idx == IDX_TX) begin
        if (r_next.txfull)
          r_next.flags[ST_TXWR] = 1'b1;
        r_next.txb    = pwdata[7:0];
        r_next.txfull = 1'b1;
      end
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  property p_pin_route;
    @(posedge pclk) disable iff (!presetn)
    !psel_i2c |-> (scl_oe == spi_sclk_oe) && (sda_oe == spi_mosi_oe);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pins not routed to spi");

  property p_low_only;
    @(posedge pclk) disable iff (!presetn)
    psel_i2c |-> !scl_o && !sda_o;
  endproperty
  a_low_only: assert property (p_low_only) else $error("pin driven high");

  property p_start_idle;
    @(posedge pclk) disable iff (!presetn)
    (r_reg.st == S_IDLE) ##1 (r_reg.st == S_START) |-> $past(scl_i && sda_i, 1);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start on busy bus");

  property p_nack_halt;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_BIT && r_reg.ph == 2'b11 && r_reg.bitc == ACK_BIT
      && r_reg.is_adr && r_reg.nack |=> r_reg.flags[ST_NOACK] && r_reg.st == S_STOP;
  endproperty
  a_nack_halt: assert property (p_nack_halt) else $error("nack not flagged");

  property p_enable;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == S_IDLE && !r_reg.mode[MODE_EN_BIT] |=> r_reg.st == S_IDLE;
  endproperty
  a_enable: assert property (p_enable) else $error("launch while disabled");

  property p_div_fast;
    @(posedge pclk) disable iff (!presetn)
    tick && ce && r_reg.mode[6:5] == 2'b00 && r_next.st != S_IDLE
      ##1 ce[*3] |-> ##1 tick;
  endproperty
  a_div_fast: assert property (p_div_fast) else $error("quarter period wrong");

  property p_rx_store;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_BIT && r_reg.ph == 2'b11 && r_reg.bitc == ACK_BIT
      && !r_reg.is_adr && r_reg.rd |=> r_reg.flags[ST_RX] && r_reg.rxb == $past(r_reg.sh);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("rx byte not stored");

  property p_stop_idle;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_STOP && r_reg.ph == 2'b11 |=> r_reg.st == S_IDLE && !scl_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no idle after stop");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    r_reg.flags[ST_NOACK] && r_reg.mask[ST_NOACK] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_ack_gen;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_BIT && r_reg.ph == 2'b00 && r_reg.bitc == ACK_BIT
      && !r_reg.is_adr && r_reg.rd |=> r_reg.sda_dr == !$past(last);
  endproperty
  a_ack_gen: assert property (p_ack_gen) else $error("master ack wrong");

  property p_tx_load;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_BIT && r_reg.ph == 2'b11 && r_reg.bitc == ACK_BIT && r_reg.txfull
      && (r_reg.is_adr ? !r_reg.adr[0] : !r_reg.rd) && !r_reg.nack && !r_reg.pend
      |=> r_reg.sh == $past(r_reg.txb) && r_reg.flags[ST_TX];
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx byte not loaded");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_BIT && r_reg.ph == 2'b11 && r_reg.bitc == ACK_BIT && r_reg.pend
      && !((r_reg.is_adr || !r_reg.rd) && r_reg.nack)
      |=> r_reg.st == S_RESTART;
  endproperty
  a_restart: assert property (p_restart) else $error("no repeated start");

  property p_read_stop;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_BIT && r_reg.ph == 2'b11 && r_reg.bitc == ACK_BIT
      && !r_reg.is_adr && r_reg.rd && last && !r_reg.pend |=> r_reg.st == S_STOP;
  endproperty
  a_read_stop: assert property (p_read_stop) else $error("read not ended");

  property p_adr_first;
    @(posedge pclk) disable iff (!presetn)
    tick && r_reg.st == S_START && r_reg.ph == 2'b01
      |=> r_reg.is_adr && r_reg.sh == r_reg.adr;
  endproperty
  a_adr_first: assert property (p_adr_first) else $error("address not first");

  c_write_byte: cover property (@(posedge pclk) disable iff (!presetn)
    r_reg.st == S_BIT && !r_reg.rd && !r_reg.is_adr ##1 r_reg.st == S_STOP);
  c_read_byte: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(r_reg.flags[ST_RX]));
  c_nack: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(r_reg.flags[ST_NOACK]));
  c_restart: cover property (@(posedge pclk) disable iff (!presetn)
    r_reg.st == S_RESTART);

endmodule

// file: i2cm_slave_model.sv
// Behavioural two-wire slave for the bus master bench
`timescale 1ns/1ps
module i2cm_slave_model
#(
  parameter logic [6:0] SLV_ADDR = 7'h2A
)(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_data,
  output logic            sda_oe,
  output logic [7:0]      wr_byte,
  output int              rd_count
);
  int         cnt;
  logic       first, rd, act;
  logic [7:0] sh;
  initial begin
    {sda_oe, first, rd, act, sh, wr_byte} = 20'h0;
    cnt = 0;
    rd_count = 0;
  end
  always @(negedge sda) if (scl) begin
    cnt = -1;
    first = 1'b1;
    act = 1'b1;
    sda_oe = 1'b0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else if (rd && !first && sda) act = 1'b0;
  end
  always @(negedge scl) if (act) begin
    cnt = cnt + 1;
    sda_oe = 1'b0;
    if (cnt == 9) begin
      cnt = 0;
      first = 1'b0;
    end
    if (cnt == 8 && first) begin
      rd = sh[0];
      sda_oe = (sh[7:1] == SLV_ADDR);
      act = sda_oe;
    end else if (cnt == 8 && !rd) begin
      sda_oe = 1'b1;
      wr_byte = sh;
    end else if (rd && !first && cnt < 8) begin
      if (cnt == 0) rd_count = rd_count + 1;
      sda_oe = ~rd_data[7 - cnt];
    end
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import i2cm_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic [3:0]  spi;
  logic        scl_w, sda_w, s_oe;
  logic [7:0]  s_rd, s_wr, d;
  logic [7:0]  ids [6] = '{IDX_RX, IDX_CFG, IDX_MODE, IDX_ADR, IDX_STAT, IDX_MASK};
  logic [7:0]  exp_q [$];
  int          s_cnt, fail_count, checks, seed, n, c0;
  assign scl_w = scl_oe ? scl_o : 1'b1;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~s_oe;
  i2cm_master dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_o(sda_o), .sda_oe(sda_oe), .spi_sclk_o(spi[3]), .spi_sclk_oe(spi[2]),
    .spi_mosi_o(spi[1]), .spi_mosi_oe(spi[0]), .irq(irq));
  i2cm_slave_model #(.SLV_ADDR(7'h2A)) slv_u (.scl(scl_w), .sda(sda_w), .rd_data(s_rd),
    .sda_oe(s_oe), .wr_byte(s_wr), .rd_count(s_cnt));
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {rdv, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic scl_period(output int p);
    int k;
    {k, p} = 0;
    while (scl_w !== 1'b0 && k < 3000) begin @(posedge pclk); k++; end
    while (scl_w !== 1'b1 && k < 3000) begin @(posedge pclk); k++; end
    while (scl_w === 1'b1 && k < 3000) begin @(posedge pclk); k++; p++; end
    while (scl_w === 1'b0 && k < 3000) begin @(posedge pclk); k++; p++; end
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    repeat (8) @(posedge pclk);
    apb(1'b0, IDX_STAT, 8'h00);
    while (rdv[ST_BUSY] !== 1'b0 && k < 4000) begin apb(1'b0, IDX_STAT, 8'h00); k++; end
    `CHK({rdv[ST_BUSY], scl_w, sda_w}, 3'b011)
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #(40 * 90000);
    fail_count++;
    tally_and_finish;
  end
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    {presetn, ce, psel, penable, pwrite, paddr, pwdata, spi, s_rd} = 59'h0;
    {fail_count, checks} = 0;
    seed = 32'hBD43;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    ce <= 1'b1;
    foreach (ids[i]) begin apb(1'b0, ids[i], 8'h00); `CHK(rdv, 32'h0) end
    apb(1'b0, 8'h10, 8'h00);
    `CHK({err, rdv}, 33'h100000000)
    repeat (4) begin
      spi <= 4'($random(seed));
      repeat (2) @(posedge pclk);
      `CHK({scl_o, scl_oe, sda_o, sda_oe}, spi)
    end
    ce <= 1'b0;
    apb(1'b1, IDX_MASK, 8'hFF);
    ce <= 1'b1;
    apb(1'b0, IDX_MASK, 8'h00);
    `CHK(rdv, 32'h0)
    apb(1'b1, IDX_CFG, 8'h01);
    apb(1'b1, IDX_MASK, STAT_FLAGS);
    apb(1'b1, IDX_ADR, 8'h54);
    repeat (40) @(posedge pclk);
    `CHK({scl_w, sda_w, scl_o, sda_o}, 4'hC)
    $display("test idle done");
    d = 8'($random(seed));
    exp_q.push_back(d);
    apb(1'b1, IDX_MODE, 8'h80);
    apb(1'b1, IDX_TX, d);
    apb(1'b1, IDX_ADR, 8'h54);
    scl_period(n);
    `CHK(n, DIV_BASE)
    wait_idle();
    `CHK(s_wr, exp_q.pop_front())
    apb(1'b0, IDX_STAT, 8'h00);
    `CHK(rdv[6:2], 5'b00100)
    `CHK(irq, 1'b1)
    apb(1'b1, IDX_STAT, 8'h00);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("test write done");
    for (int r = 0; r < 4; r++) begin
      s_rd = 8'($random(seed));
      exp_q.push_back(s_rd);
      c0 = s_cnt;
      apb(1'b1, IDX_MODE, 8'h80 | 8'(r << 5) | 8'(r));
      apb(1'b1, IDX_ADR, 8'h55);
      scl_period(n);
      `CHK(n, DIV_BASE << r)
      wait_idle();
      `CHK(s_cnt - c0, r + 1)
      apb(1'b0, IDX_RX, 8'h00);
      `CHK(rdv[7:0], exp_q.pop_front())
      apb(1'b0, IDX_STAT, 8'h00);
      `CHK(rdv[ST_RX], 1'b1)
      apb(1'b1, IDX_STAT, 8'h00);
    end
    $display("test read done");
    s_rd = 8'($random(seed));
    exp_q.push_back(s_rd);
    c0 = s_cnt;
    apb(1'b1, IDX_MODE, 8'h80);
    apb(1'b1, IDX_ADR, 8'h54);
    repeat (40) @(posedge pclk);
    apb(1'b1, IDX_ADR, 8'h55);
    wait_idle();
    `CHK(s_cnt - c0, 1)
    apb(1'b0, IDX_RX, 8'h00);
    `CHK(rdv[7:0], exp_q.pop_front())
    apb(1'b1, IDX_STAT, 8'h00);
    $display("test restart done");
    apb(1'b1, IDX_MODE, 8'h80);
    apb(1'b1, IDX_TX, 8'hA5);
    apb(1'b1, IDX_ADR, 8'h22);
    wait_idle();
    apb(1'b0, IDX_STAT, 8'h00);
    `CHK({rdv[ST_NOACK], rdv[3:2]}, 3'b100)
    `CHK(irq, 1'b1)
    apb(1'b1, IDX_MASK, 8'h00);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, IDX_STAT, 8'h00);
    apb(1'b0, IDX_STAT, 8'h00);
    `CHK(rdv[ST_NOACK], 1'b0)
    $display("test nack done");
    tally_and_finish();
  end
endmodule
